//--- rtl/dram_array_defines.vh
`ifndef DRAM_ARRAY_DEFINES_VH
`define DRAM_ARRAY_DEFINES_VH

// ----------------------------------------------------------------
// Bus layout
// ----------------------------------------------------------------
`define BUS_W        22
`define DATA_W       16
`define CHECK_W      6
`define CHECK_LSB    16
`define ROW_ADDR_W   7
`define CHIP_ADDR_W  7
`define WIN_ADDR_W   12
`define BANK_W       2

// ----------------------------------------------------------------
// Reset and misc values
// ----------------------------------------------------------------
`define ROWS_RD      2'h3
`define ROW_EVEN     2'h1
`define ROW_ODD      2'h2
`define ROWS_NONE    2'h0

`endif

//--- rtl/array_store.v
`timescale 1ns/1ps
`include "dram_array_defines.vh"

// Small word store standing in for the array chips; read data registered
module array_store
#(
	parameter AW = 10,
	parameter DW = 22
)
(
	// Clock
	input  wire          core_clk,
	// Write side
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	// Read side
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data_q
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// No reset on contents: dynamic cells hold garbage after power-up anyway
	always @(posedge core_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= mem[rd_addr];
	end

endmodule

//--- rtl/dram_array_if.v
`timescale 1ns/1ps
`include "dram_array_defines.vh"

// How it works
// - 22-bit shared bidirectional bus, top six lines carry check bits.
// - Assert array_selected_n when the bus address falls in the configured window and refresh is not active.
// - Read enables both rows; write enables only the addressed odd or even row.
// - Falling row_strobe_n latches seven row address bits.
// - column_group_select switches the mux to the second seven address bits.
// - Falling column_strobe_n latches seven column bits after column group select.
// - While refresh is active, refresh lines feed the chips, latched by row strobe.
// - All chip strobes suppressed while power_good_n is high.
// - io_reset_n low clears each error lamp, except in a cycle where that lamp is being set.
// - Multibit error during a read sets the selected board's lamp.
// - Correctable error during a read sets the selected board's lamp.
module dram_array_if
#(
	parameter WIN_BASE = 12'h000,
	parameter WIN_SIZE = 12'h040,
	parameter STORE_AW = 10
)
(
	// Clock and reset
	core_clk,
	srst,
	// Configuration straps
	addr_switch,
	size_jumper,
	// Address and control from controller
	bus_addr,
	rd_wr_ctl_n,
	odd_word_addr,
	row_strobe_n,
	column_group_select,
	column_strobe_n,
	refresh_row_addr_n,
	refresh_active_n,
	supply_switch_en_n,
	power_good_n,
	io_reset_n,
	multibit_err_n,
	single_bit_err_n,
	// Shared data bus
	mem_bus_line_in,
	mem_bus_line_out,
	mem_bus_line_oe,
	// Board outputs
	array_selected_n,
	row_enable,
	chip_row_strobe_n,
	chip_column_strobe_n,
	chip_addr,
	multibit_lamp,
	correctable_lamp,
	array_powered
);
	input  wire                     core_clk;
	input  wire                     srst;
	input  wire [`WIN_ADDR_W-1:0]   addr_switch;
	input  wire [`WIN_ADDR_W-1:0]   size_jumper;
	input  wire [`WIN_ADDR_W+`BANK_W+2*`ROW_ADDR_W-1:0] bus_addr;
	input  wire                     rd_wr_ctl_n;
	input  wire                     odd_word_addr;
	input  wire                     row_strobe_n;
	input  wire                     column_group_select;
	input  wire                     column_strobe_n;
	input  wire [`ROW_ADDR_W-1:0]   refresh_row_addr_n;
	input  wire                     refresh_active_n;
	input  wire                     supply_switch_en_n;
	input  wire                     power_good_n;
	input  wire                     io_reset_n;
	input  wire                     multibit_err_n;
	input  wire                     single_bit_err_n;
	input  wire [`BUS_W-1:0]        mem_bus_line_in;
	output reg  [`BUS_W-1:0]        mem_bus_line_out;
	output reg  [`BUS_W-1:0]        mem_bus_line_oe;
	output reg                      array_selected_n;
	output reg  [1:0]               row_enable;
	output reg                      chip_row_strobe_n;
	output reg                      chip_column_strobe_n;
	output reg  [`CHIP_ADDR_W-1:0]  chip_addr;
	output reg                      multibit_lamp;
	output reg                      correctable_lamp;
	output reg                      array_powered;

	// Cycle states, one-hot
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_ROW  = 4'h2;
	localparam [3:0] ST_COL  = 4'h4;
	localparam [3:0] ST_RFSH = 4'h8;

	// ----------------------------------------------------------------
	// Address split
	// ----------------------------------------------------------------
	wire [`ROW_ADDR_W-1:0]  row_bits = bus_addr[`ROW_ADDR_W-1:0];
	wire [`ROW_ADDR_W-1:0]  col_bits = bus_addr[2*`ROW_ADDR_W-1:`ROW_ADDR_W];
	wire [`WIN_ADDR_W-1:0]  win_addr = bus_addr[`WIN_ADDR_W+`BANK_W+2*`ROW_ADDR_W-1:
		`BANK_W+2*`ROW_ADDR_W];

	// Window check; used for select and for lamp qualification
	function in_window;
		input [`WIN_ADDR_W-1:0] a;
		input [`WIN_ADDR_W-1:0] base;
		input [`WIN_ADDR_W-1:0] size;
		begin
			in_window = (a >= base) && ((a - base) < size);
		end
	endfunction

	wire hit = in_window(win_addr, addr_switch, size_jumper);
	wire powered_ok = ~power_good_n;
	wire is_read = rd_wr_ctl_n;                                  // high = read
	wire refreshing = ~refresh_active_n;

	// ----------------------------------------------------------------
	// Strobe edge tracking
	// ----------------------------------------------------------------
	reg row_strobe_q;
	reg col_strobe_q;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [`ROW_ADDR_W-1:0] row_latch_q;
	reg [`ROW_ADDR_W-1:0] col_latch_q;
	reg                   rd_cycle_q;

	wire row_fall = row_strobe_q & ~row_strobe_n;
	wire col_fall = col_strobe_q & ~column_strobe_n;

	// Next-state: refresh takes priority since it owns the address path
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (row_fall && powered_ok)
					state_d = refreshing ? ST_RFSH : ST_ROW;
			ST_ROW:
				if (row_strobe_n)
					state_d = ST_IDLE;
				else if (col_fall && column_group_select && powered_ok)
					state_d = ST_COL;
			ST_COL:
				if (row_strobe_n)
					state_d = ST_IDLE;
			ST_RFSH:
				if (row_strobe_n)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Memory store addressed by latched row/column
	// Write only while the column strobe is still held low: once it rises the
	// controller may already have released the bus, and a late write would store junk
	wire [`BUS_W-1:0] store_rd;
	wire              store_wr = (state_q == ST_COL) && ~rd_cycle_q && ~column_strobe_n &&
		~array_selected_n;
	wire [2*`ROW_ADDR_W-1:0] cell_addr = {col_latch_q, row_latch_q};
	// Only the low cells are modelled; upper column bits alias
	wire [STORE_AW-1:0] store_addr = cell_addr[STORE_AW-1:0];

	array_store
	#(
		.AW (STORE_AW),
		.DW (`BUS_W)
	)
	u_store
	(
		.core_clk  (core_clk),
		.wr_en     (store_wr),
		.wr_addr   (store_addr),
		.wr_data   (~mem_bus_line_in),
		.rd_addr   (store_addr),
		.rd_data_q (store_rd)
	);

	// ----------------------------------------------------------------
	// Sequencing and outputs
	// ----------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			state_q              <= ST_IDLE;
			row_strobe_q         <= 1'b1;
			col_strobe_q         <= 1'b1;
			row_latch_q          <= {`ROW_ADDR_W{1'b0}};
			col_latch_q          <= {`ROW_ADDR_W{1'b0}};
			rd_cycle_q           <= 1'b1;
			array_selected_n     <= 1'b1;
			row_enable           <= `ROWS_NONE;
			chip_row_strobe_n    <= 1'b1;
			chip_column_strobe_n <= 1'b1;
			chip_addr            <= {`CHIP_ADDR_W{1'b0}};
			mem_bus_line_out     <= {`BUS_W{1'b1}};
			mem_bus_line_oe      <= {`BUS_W{1'b0}};
			array_powered        <= 1'b0;
		end
		else
		begin
			state_q          <= state_d;
			row_strobe_q     <= row_strobe_n;
			col_strobe_q     <= column_strobe_n;
			array_powered    <= ~supply_switch_en_n;
			array_selected_n <= ~(hit & ~refreshing);
			// Address mux: refresh lines, else column group, else row
			if (refreshing)
				chip_addr <= ~refresh_row_addr_n;
			else if (column_group_select)
				chip_addr <= col_bits;
			else
				chip_addr <= row_bits;
			// Latch on row strobe; refresh row comes from refresh lines
			if (row_fall && powered_ok)
			begin
				row_latch_q <= refreshing ? ~refresh_row_addr_n : row_bits;
				rd_cycle_q  <= is_read;
			end
			if (col_fall && column_group_select && powered_ok)
				col_latch_q <= col_bits;
			// Chip strobes pass only when power is good
			chip_row_strobe_n    <= row_strobe_n | ~powered_ok;
			chip_column_strobe_n <= column_strobe_n | ~powered_ok |
				~column_group_select | refreshing;
			// Row enables: reads take both rows, writes only the addressed one
			if (~powered_ok || refreshing || ~hit)
				row_enable <= `ROWS_NONE;
			else if (is_read)
				row_enable <= `ROWS_RD;
			else
				row_enable <= odd_word_addr ? `ROW_ODD : `ROW_EVEN;
			// Drive bus during a selected read column phase, active low lines
			if (state_q == ST_COL && rd_cycle_q && ~array_selected_n)
			begin
				mem_bus_line_out <= ~store_rd;
				mem_bus_line_oe  <= {`BUS_W{1'b1}};
			end
			else
			begin
				mem_bus_line_out <= {`BUS_W{1'b1}};
				mem_bus_line_oe  <= {`BUS_W{1'b0}};
			end
		end
	end

	// ----------------------------------------------------------------
	// Error lamps
	// ----------------------------------------------------------------
	// Set beats clear so an error in the reset cycle is still shown
	wire lamp_ok = ~array_selected_n & rd_cycle_q;
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			multibit_lamp    <= 1'b0;
			correctable_lamp <= 1'b0;
		end
		else
		begin
			if (lamp_ok && ~multibit_err_n)
				multibit_lamp <= 1'b1;
			else if (~io_reset_n)
				multibit_lamp <= 1'b0;
			if (lamp_ok && ~single_bit_err_n)
				correctable_lamp <= 1'b1;
			else if (~io_reset_n)
				correctable_lamp <= 1'b0;
		end
	end

endmodule

//--- tb/dram_array_if_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the array board
// ----------------------------------------
module dram_array_if_assertions
(
	// Clock and reset
	input wire       core_clk,
	input wire       srst,
	// Controller lines
	input wire       rd_wr_ctl_n,
	input wire       refresh_active_n,
	input wire       power_good_n,
	input wire       io_reset_n,
	input wire       multibit_err_n,
	input wire       single_bit_err_n,
	// Board outputs
	input wire       array_selected_n,
	input wire [1:0] row_enable,
	input wire       chip_row_strobe_n,
	input wire       chip_column_strobe_n,
	input wire       multibit_lamp,
	input wire       correctable_lamp
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	// Bad power must starve the chips of every strobe and row
	pwr_strobe_a: assert property (power_good_n |=> chip_row_strobe_n && chip_column_strobe_n)
		else $error("strobe with power bad");
	pwr_rows_a: assert property (power_good_n |=> row_enable == 2'h0)
		else $error("row enabled with power bad");
	// Both rows only when the previous sample was a read
	rows_read_a: assert property (row_enable == 2'h3 |-> $past(rd_wr_ctl_n))
		else $error("both rows on a write");
	// Refresh owns the chips: no select, no column strobe
	ref_sel_a: assert property (!refresh_active_n |=> array_selected_n)
		else $error("selected during refresh");
	ref_col_a: assert property (!refresh_active_n |=> chip_column_strobe_n)
		else $error("column strobe during refresh");
	// Lamps: set wins over clear, so clear is checked with no error present
	lamp_clr_a: assert property (!io_reset_n && multibit_err_n && single_bit_err_n
		|=> !multibit_lamp && !correctable_lamp)
		else $error("lamp not cleared");
	lamp_mb_a: assert property (!multibit_err_n && !array_selected_n && rd_wr_ctl_n
		|=> multibit_lamp)
		else $error("multibit lamp not set");
	lamp_ce_a: assert property (!single_bit_err_n && !array_selected_n && rd_wr_ctl_n
		|=> correctable_lamp)
		else $error("correctable lamp not set");

	// Main scenarios reached
	cover property (!array_selected_n && rd_wr_ctl_n);
	cover property (row_enable == 2'h2);
	cover property (multibit_lamp && correctable_lamp);
endmodule

bind dram_array_if dram_array_if_assertions chk_i (.core_clk, .srst, .rd_wr_ctl_n,
	.refresh_active_n, .power_good_n, .io_reset_n, .multibit_err_n, .single_bit_err_n,
	.array_selected_n, .row_enable, .chip_row_strobe_n, .chip_column_strobe_n,
	.multibit_lamp, .correctable_lamp);

//--- tb/ctl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory controller seen from the array
// ----------------------------------------
module ctl_model
(
	// Clock
	input wire         core_clk,
	// Board answers
	input wire         array_selected_n,
	input wire  [1:0]  row_enable,
	input wire  [21:0] bus_in,
	// Controller drive
	output logic        rd_wr_ctl_n,
	output logic        odd_word_addr,
	output logic        row_strobe_n,
	output logic        column_group_select,
	output logic        column_strobe_n,
	output logic [27:0] bus_addr,
	output logic [21:0] bus_drv,
	output logic        bus_oe,
	// Snapshots for the bench
	output logic        sel_seen,
	output logic [1:0]  rows_seen,
	output logic [21:0] rd_seen
);
	// Idle: strobes high, bus released
	initial
	begin
		{row_strobe_n, column_strobe_n, rd_wr_ctl_n} = 3'h7;
		{column_group_select, odd_word_addr, bus_oe} = 3'h0;
		bus_addr = 28'h0;
		bus_drv = 22'h0;
	end

	// One memory cycle, called at a falling edge; data sent active low
	task cycle(input logic rd, input logic odd, input logic [27:0] a, input logic [21:0] wd);
	begin
		rd_wr_ctl_n = rd;
		odd_word_addr = odd;
		bus_addr = a;
		bus_oe = !rd;
		bus_drv = ~wd;
		@(negedge core_clk);
		row_strobe_n = 1'b0;
		repeat (2) @(negedge core_clk);
		sel_seen = array_selected_n;
		rows_seen = row_enable;
		column_group_select = 1'b1;
		@(negedge core_clk);
		column_strobe_n = 1'b0;
		repeat (4) @(negedge core_clk);
		rd_seen = ~bus_in;
		{row_strobe_n, column_strobe_n} = 2'h3;
		column_group_select = 1'b0;
		bus_oe = 1'b0;
		bus_drv = ~bus_drv;
		repeat (3) @(negedge core_clk);
	end
	endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk, srst, io_reset_n, multibit_err_n, single_bit_err_n;
	logic refresh_active_n, supply_switch_en_n, power_good_n;
	logic [11:0] addr_switch, size_jumper;
	logic [6:0] refresh_row_addr_n;
	logic rd_wr_ctl_n, odd_word_addr, row_strobe_n, column_group_select, column_strobe_n;
	logic [27:0] bus_addr;
	logic [21:0] bus_drv, mem_bus_line_out, mem_bus_line_oe, rd_seen;
	logic bus_oe, sel_seen, array_selected_n, chip_row_strobe_n, chip_column_strobe_n;
	logic [1:0] row_enable, rows_seen;
	logic [6:0] chip_addr;
	logic multibit_lamp, correctable_lamp, array_powered;
	wire [21:0] bus_w;
	int num_errors, tests_run, cycles;
	localparam logic [27:0] HIT = 28'h0110123;
	localparam logic [27:0] HIT2 = 28'h0120456;

	// Released lines float up through the pull-ups
	assign bus_w = (mem_bus_line_oe & mem_bus_line_out)
		| (~mem_bus_line_oe & (bus_oe ? bus_drv : 22'h3FFFFF));

	dram_array_if dram_array_if_i (.core_clk, .srst, .addr_switch, .size_jumper, .bus_addr,
		.rd_wr_ctl_n, .odd_word_addr, .row_strobe_n, .column_group_select,
		.column_strobe_n, .refresh_row_addr_n, .refresh_active_n, .supply_switch_en_n,
		.power_good_n, .io_reset_n, .multibit_err_n, .single_bit_err_n,
		.mem_bus_line_in(bus_w), .mem_bus_line_out, .mem_bus_line_oe, .array_selected_n,
		.row_enable, .chip_row_strobe_n, .chip_column_strobe_n, .chip_addr,
		.multibit_lamp, .correctable_lamp, .array_powered);
	ctl_model ctl_model_i (.core_clk, .array_selected_n, .row_enable, .bus_in(bus_w),
		.rd_wr_ctl_n, .odd_word_addr, .row_strobe_n, .column_group_select,
		.column_strobe_n, .bus_addr, .bus_drv, .bus_oe, .sel_seen, .rows_seen, .rd_seen);

	// ----------------------------------------
	// Checking and verdict
	// ----------------------------------------
	task check(input logic [27:0] seen, input logic [27:0] exp);
	begin
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task give_verdict;
	begin
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	// Clock and hang guard; a run takes just under a hundred cycles
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			give_verdict;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_write;
	begin
		ctl_model_i.cycle(1'b0, 1'b1, HIT, 22'h2A5A5C);
		check(sel_seen, 1'b0);
		check(rows_seen, 2'h2);
		ctl_model_i.cycle(1'b0, 1'b0, HIT2, 22'h15A3C1);
		check(rows_seen, 2'h1);
		ctl_model_i.cycle(1'b1, 1'b0, HIT, 22'h0);
		check(rows_seen, 2'h3);
		check(rd_seen, 22'h2A5A5C);
		ctl_model_i.cycle(1'b1, 1'b1, HIT2, 22'h0);
		check(rd_seen, 22'h15A3C1);
		ctl_model_i.cycle(1'b1, 1'b0, 28'h0200123, 22'h0);
		check(sel_seen, 1'b1);
		check(chip_addr, 7'h23);
	end
	endtask

	task t_lamps;
	begin
		{multibit_err_n, single_bit_err_n} = 2'h0;
		ctl_model_i.cycle(1'b1, 1'b0, HIT, 22'h0);
		{multibit_err_n, single_bit_err_n} = 2'h3;
		@(negedge core_clk);
		check(multibit_lamp, 1'b1);
		check(correctable_lamp, 1'b1);
		io_reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		io_reset_n = 1'b1;
		check({multibit_lamp, correctable_lamp}, 2'h0);
	end
	endtask

	task t_refresh_power;
	begin
		refresh_active_n = 1'b0;
		refresh_row_addr_n = 7'h55;
		ctl_model_i.cycle(1'b1, 1'b0, HIT, 22'h0);
		check(sel_seen, 1'b1);
		check(chip_addr, 7'h2A);
		refresh_active_n = 1'b1;
		power_good_n = 1'b1;
		ctl_model_i.cycle(1'b1, 1'b0, HIT, 22'h0);
		check(rows_seen, 2'h0);
		power_good_n = 1'b0;
	end
	endtask

	// Main sequence
	initial
	begin
		{srst, io_reset_n, multibit_err_n, single_bit_err_n, refresh_active_n} = 5'h1F;
		supply_switch_en_n = 1'b0;
		power_good_n = 1'b0;
		addr_switch = 12'h010;
		size_jumper = 12'h004;
		refresh_row_addr_n = 7'h7F;
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		check(mem_bus_line_oe, 22'h0);
		check({array_selected_n, chip_row_strobe_n, chip_column_strobe_n}, 3'h7);
		check({multibit_lamp, correctable_lamp, row_enable}, 4'h0);
		@(negedge core_clk);
		check(array_powered, 1'b1);
		t_write;
		t_lamps;
		t_refresh_power;
		give_verdict;
	end
endmodule
